// file: design/efs_pkg.sv
// Constants shared by the E1 frame sync status and indication block.
package efs_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_MODE = 10'h04e;
    localparam logic [9:0] IDX_STAT = 10'h04f;
    localparam logic [9:0] IDX_EN0 = 10'h050;
    localparam logic [9:0] IDX_EN1 = 10'h051;
    localparam logic [9:0] IDX_CHG = 10'h052;
    localparam logic [9:0] IDX_EVT = 10'h053;
    // Mode register fields.
    localparam int MODE_KEEP = 0;
    localparam int MODE_SIGCHK = 1;
    localparam int MODE_ZRUN2 = 2;
    localparam logic [2:0] MODE_RST = 3'h0;
    // Status register fields and reset value.
    localparam int ST_BASIC = 0;
    localparam int ST_OFFL = 1;
    localparam int ST_CRC = 2;
    localparam int ST_CAS = 3;
    localparam int ST_IW = 4;
    localparam logic [4:0] STAT_RST = 5'h0d;
    // Position of the excessive CRC-4 flag in the change flag register.
    localparam int CHG_EXCESS = 5;
    // Event flag positions.
    localparam int EV_SIGPOS = 7;
    localparam int EV_SUBPOS = 6;
    localparam int EV_SIGERR = 5;
    localparam int EV_CRCPOS = 4;
    localparam int EV_CRCERR = 3;
    localparam int EV_CRC4 = 2;
    localparam int EV_FBIT = 1;
    localparam int EV_MOVE = 0;
    // Expected alignment words.
    localparam logic [3:0] CAS_MFA = 4'h0;
    localparam logic [5:0] CRC_MFA = 6'h0b;
    // Loss criteria counts.
    localparam logic [1:0] CAS_ERR_LIMIT = 2'h2;
    // Excessive CRC-4 threshold and its window.
    localparam logic [9:0] EXCESS_LIMIT = 10'h393;
    localparam int WINDOW_MS = 1000;
    localparam int CLK_KHZ = 250000;
    localparam int WINDOW_CYC = WINDOW_MS * CLK_KHZ;
    // CAS multi-frame sync states.
    typedef enum logic [0:0] {
        CAS_LOCK = 1'b0,
        CAS_LOST = 1'b1
    } efs_cas_t;
endpackage : efs_pkg

// file: design/efs_frame_sync_status.sv
// E1 receive frame sync status, change and event flags, and interrupt gating.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

module efs_frame_sync_status
    import efs_pkg::*;
#(
    parameter int WIN_CYC = WINDOW_CYC
) (
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sync levels from the search engines.
    input wire logic basic_frame_lost_in,
    input wire logic offline_frame_lost_in,
    input wire logic crc_mf_lost_in,
    input wire logic interwork_in,
    // CAS multi-frame strobes.
    input wire logic cas_mf_found,
    input wire logic cas_mf_start,
    input wire logic [3:0] cas_mfa_bits,
    input wire logic ts16_zero_mf,
    // CRC multi-frame strobes.
    input wire logic crc_mf_start,
    input wire logic [5:0] crc_mfa_bits,
    input wire logic crc_submf_start,
    input wire logic [3:0] crc4_calc,
    input wire logic [3:0] crc4_rx,
    // Basic frame strobes.
    input wire logic frame_bit_err,
    input wire logic align_found,
    input wire logic [7:0] align_pos,
    // Outputs to the framer and the system.
    output logic crc_search_en,
    output logic cas_mf_lost_state,
    output logic irq
);

    localparam logic [27:0] WIN_LAST = 28'(WIN_CYC - 1);

    logic [2:0] mode_q;
    logic [4:0] stat_q;
    logic [4:0] stat_d;
    logic [4:0] en0_q;
    logic [7:0] en1_q;
    logic [5:0] chg_q;
    logic [7:0] evt_q;
    logic [7:0] ev;
    logic [5:0] chg_set;
    logic [1:0] cas_err_q;
    logic [1:0] zrun_q;
    logic [9:0] xcnt_q;
    logic [27:0] win_q;
    logic [7:0] pos_q;
    logic pos_vld_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic crc_search_en_q;
    logic irq_q;
    efs_cas_t cas_q;
    efs_cas_t cas_d;
    logic cas_chk;
    logic mfa_err;
    logic zero_loss;
    logic excess;
    logic [9:0] idx;
    logic setup;
    logic wr;
    logic [31:0] rd_mux;
    logic rd_bad;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign crc_search_en = crc_search_en_q;
    assign cas_mf_lost_state = stat_q[ST_CAS];
    assign irq = irq_q;

    // APB decode; accesses complete one cycle after setup.
    assign idx = paddr[11:2];
    assign setup = psel && !penable;
    assign wr = psel && penable && pready_q && pwrite && !pslverr_q;

    always_comb begin
        rd_mux = 32'h0;
        rd_bad = 1'b0;
        unique case (idx)
            IDX_MODE: rd_mux[2:0] = mode_q;
            IDX_STAT: rd_mux[4:0] = stat_q;
            IDX_EN0: rd_mux[4:0] = en0_q;
            IDX_EN1: rd_mux[7:0] = en1_q;
            IDX_CHG: rd_mux[5:0] = chg_q;
            IDX_EVT: rd_mux[7:0] = evt_q;
            default: rd_bad = 1'b1;
        endcase
        if (paddr[1:0] != 2'h0) begin
            rd_bad = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            if (setup) begin
                pready_q <= 1'b1;
                pslverr_q <= rd_bad;
                prdata_q <= (pwrite || rd_bad) ? 32'h0 : rd_mux;
            end else begin
                pready_q <= 1'b0;
                pslverr_q <= 1'b0;
            end
        end
    end

    // Software controls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RST;
            en0_q <= 5'h0;
            en1_q <= 8'h0;
        end else if (ce && wr) begin
            if (idx == IDX_MODE) begin
                mode_q <= pwdata[2:0];
            end
            if (idx == IDX_EN0) begin
                en0_q <= pwdata[4:0];
            end
            if (idx == IDX_EN1) begin
                en1_q <= pwdata[7:0];
            end
        end
    end

    // CAS multi-frame loss criteria.
    assign cas_chk = (cas_q == CAS_LOCK) && cas_mf_start;
    assign mfa_err = cas_mfa_bits != CAS_MFA;
    assign zero_loss = mode_q[MODE_SIGCHK] && ts16_zero_mf
        && (!mode_q[MODE_ZRUN2] || zrun_q != 2'h0);

    always_comb begin
        cas_d = cas_q;
        unique case (cas_q)
            CAS_LOCK: begin
                if (basic_frame_lost_in) begin
                    cas_d = CAS_LOST;
                end else if (cas_chk && mfa_err
                    && cas_err_q == CAS_ERR_LIMIT - 2'h1) begin
                    cas_d = CAS_LOST;
                end else if (cas_chk && zero_loss) begin
                    cas_d = CAS_LOST;
                end
            end
            CAS_LOST: begin
                if (cas_mf_found && !basic_frame_lost_in) begin
                    cas_d = CAS_LOCK;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cas_q <= CAS_LOST;
            cas_err_q <= 2'h0;
            zrun_q <= 2'h0;
        end else if (ce) begin
            cas_q <= cas_d;
            if (cas_d == CAS_LOST) begin
                cas_err_q <= 2'h0;
                zrun_q <= 2'h0;
            end else if (cas_chk) begin
                cas_err_q <= mfa_err ? cas_err_q + 2'h1 : 2'h0;
                zrun_q <= ts16_zero_mf ? 2'h1 : 2'h0;
            end
        end
    end

    // Status register.
    assign stat_d[ST_IW] = interwork_in;
    assign stat_d[ST_CAS] = cas_d == CAS_LOST;
    assign stat_d[ST_CRC] = crc_mf_lost_in;
    assign stat_d[ST_OFFL] = offline_frame_lost_in;
    assign stat_d[ST_BASIC] = basic_frame_lost_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= STAT_RST;
        end else if (ce) begin
            stat_q <= stat_d;
        end
    end

    // Search control back to the CRC engine.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_search_en_q <= 1'b1;
        end else if (ce) begin
            crc_search_en_q <= !(interwork_in && !mode_q[MODE_KEEP]);
        end
    end

    // Excessive CRC-4 counting over fixed windows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xcnt_q <= 10'h0;
            win_q <= 28'h0;
        end else if (ce) begin
            if (stat_q[ST_CRC]) begin
                xcnt_q <= 10'h0;
                win_q <= 28'h0;
            end else if (win_q == WIN_LAST) begin
                xcnt_q <= 10'h0;
                win_q <= 28'h0;
            end else begin
                win_q <= win_q + 28'h1;
                if (ev[EV_CRC4] && xcnt_q != EXCESS_LIMIT) begin
                    xcnt_q <= xcnt_q + 10'h1;
                end
            end
        end
    end

    assign excess = !stat_q[ST_CRC] && win_q != WIN_LAST && ev[EV_CRC4]
        && xcnt_q == EXCESS_LIMIT - 10'h1;

    // Alignment position memory.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 8'h0;
            pos_vld_q <= 1'b0;
        end else if (ce && align_found) begin
            pos_q <= align_pos;
            pos_vld_q <= 1'b1;
        end
    end

    // Event strobes, each except the alignment move gated by the sync it depends on.
    assign ev[EV_SIGPOS] = cas_mf_start && !stat_q[ST_CAS];
    assign ev[EV_SUBPOS] = crc_submf_start && !stat_q[ST_CRC];
    assign ev[EV_SIGERR] = cas_mf_start && !stat_q[ST_CAS] && mfa_err;
    assign ev[EV_CRCPOS] = crc_mf_start && !stat_q[ST_CRC];
    assign ev[EV_CRCERR] = crc_mf_start && !stat_q[ST_CRC]
        && crc_mfa_bits != CRC_MFA;
    assign ev[EV_CRC4] = crc_submf_start && !stat_q[ST_CRC]
        && crc4_calc != crc4_rx;
    assign ev[EV_FBIT] = frame_bit_err && !stat_q[ST_BASIC];
    assign ev[EV_MOVE] = align_found && pos_vld_q && align_pos != pos_q;

    assign chg_set = {excess, stat_d ^ stat_q};

    // Sticky flags; a new event wins over a clearing write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_q <= 6'h0;
            evt_q <= 8'h0;
        end else if (ce) begin
            chg_q <= (chg_q & ~((wr && idx == IDX_CHG) ? pwdata[5:0] : 6'h0))
                | chg_set;
            evt_q <= (evt_q & ~((wr && idx == IDX_EVT) ? pwdata[7:0] : 8'h0))
                | ev;
        end
    end

    // Interrupt output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(chg_q[4:0] & en0_q) || |(evt_q & en1_q);
        end
    end

    property p_cas_two_err;
        @(posedge pclk) disable iff (!presetn)
        (ce && cas_q == CAS_LOCK && cas_mf_start && mfa_err && cas_err_q == 2'h1)
            |=> stat_q[ST_CAS];
    endproperty
    a_cas_two_err: assert property (p_cas_two_err)
        else $error("CAS loss not declared after two errors");

    property p_cas_one_err;
        @(posedge pclk) disable iff (!presetn)
        (ce && cas_q == CAS_LOCK && cas_mf_start && cas_err_q == 2'h0
            && !ts16_zero_mf && !basic_frame_lost_in && !cas_mf_found)
            |=> !stat_q[ST_CAS];
    endproperty
    a_cas_one_err: assert property (p_cas_one_err)
        else $error("CAS loss declared too early");

    property p_zero_one;
        @(posedge pclk) disable iff (!presetn)
        (ce && cas_chk && ts16_zero_mf && mode_q[MODE_SIGCHK]
            && !mode_q[MODE_ZRUN2]) |=> stat_q[ST_CAS];
    endproperty
    a_zero_one: assert property (p_zero_one)
        else $error("TS16 zero run did not declare CAS loss");

    property p_search;
        @(posedge pclk) disable iff (!presetn)
        (ce && interwork_in) |=> (crc_search_en_q == $past(mode_q[MODE_KEEP]));
    endproperty
    a_search: assert property (p_search)
        else $error("CRC search enable wrong in interworking");

    property p_change;
        @(posedge pclk) disable iff (!presetn)
        (ce && $changed(stat_q[ST_BASIC])) |-> chg_q[ST_BASIC];
    endproperty
    a_change: assert property (p_change)
        else $error("Status edge did not set change flag");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (ce && evt_q[EV_FBIT] && !(wr && idx == IDX_EVT && pwdata[EV_FBIT]))
            |=> evt_q[EV_FBIT];
    endproperty
    a_hold: assert property (p_hold)
        else $error("Flag lost without a clearing write");

    property p_excess;
        @(posedge pclk) disable iff (!presetn)
        (ce && !stat_q[ST_CRC] && ev[EV_CRC4] && xcnt_q == 10'h392
            && win_q != WIN_LAST) |=> chg_q[CHG_EXCESS];
    endproperty
    a_excess: assert property (p_excess)
        else $error("Excess flag missing at 915 errors");

    property p_suspend;
        @(posedge pclk) disable iff (!presetn)
        (ce && stat_q[ST_CRC]) |=> xcnt_q == 10'h0;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("Excess counting while out of CRC sync");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        (ce && (|(chg_q[4:0] & en0_q) || |(evt_q & en1_q))) |=> irq_q;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt missing while an enabled flag is set");

    property p_irq_off;
        @(posedge pclk) disable iff (!presetn)
        (ce && !(|(chg_q[4:0] & en0_q)) && !(|(evt_q & en1_q))) |=> !irq_q;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("Interrupt high with no enabled flag set");

    property p_sigpos;
        @(posedge pclk) disable iff (!presetn)
        (ce && stat_q[ST_CAS] && !evt_q[EV_SIGPOS]) |=> !evt_q[EV_SIGPOS];
    endproperty
    a_sigpos: assert property (p_sigpos)
        else $error("Signaling position set while out of sync");

    property p_crcerr;
        @(posedge pclk) disable iff (!presetn)
        (ce && !stat_q[ST_CRC] && crc_mf_start && crc_mfa_bits != CRC_MFA)
            |=> evt_q[EV_CRCERR];
    endproperty
    a_crcerr: assert property (p_crcerr)
        else $error("CRC alignment error not flagged");

    property p_cv_cas_loss;
        @(posedge pclk) disable iff (!presetn)
        !stat_q[ST_CAS] ##1 stat_q[ST_CAS];
    endproperty
    c_cas_loss: cover property (p_cv_cas_loss);

    property p_cv_irq;
        @(posedge pclk) disable iff (!presetn)
        !irq_q ##1 irq_q ##[1:20] !irq_q;
    endproperty
    c_irq: cover property (p_cv_irq);

    property p_cv_excess;
        @(posedge pclk) disable iff (!presetn)
        !chg_q[CHG_EXCESS] ##1 chg_q[CHG_EXCESS];
    endproperty
    c_excess: cover property (p_cv_excess);

endmodule : efs_frame_sync_status

// file: verif/efs_line_model.sv
// Line-side model that drives the search engine levels and strobes of the framer.
`timescale 1ns/1ps

module efs_line_model (
    // Clock.
    input wire logic pclk,
    // Sync levels.
    output logic basic_lost,
    output logic offl_lost,
    output logic crc_lost,
    output logic iw_mode,
    // CAS multi-frame strobes.
    output logic cas_found,
    output logic cas_start,
    output logic [3:0] cas_mfa,
    output logic ts16_zero,
    // CRC multi-frame strobes.
    output logic crc_start,
    output logic [5:0] crc_mfa,
    output logic sub_start,
    output logic [3:0] crc4_calc,
    output logic [3:0] crc4_rx,
    // Basic frame strobes.
    output logic fbit_err,
    output logic al_found,
    output logic [7:0] al_pos
);
    // Levels start equal to the status reset value so no change is seen at release.
    initial begin
        {iw_mode, crc_lost, offl_lost, basic_lost} = 4'h5;
        {cas_found, cas_start, cas_mfa, ts16_zero} = 7'h00;
        {crc_start, crc_mfa, sub_start, crc4_calc, crc4_rx} = 16'h0000;
        {fbit_err, al_found, al_pos} = 10'h000;
    end

    // Level order is interworking, CRC lost, offline lost, basic lost.
    task automatic levels(input logic [3:0] v);
        @(posedge pclk);
        {iw_mode, crc_lost, offl_lost, basic_lost} <= v;
    endtask : levels

    // Data that qualifies a strobe is inverted once the strobe is gone.
    task automatic cas_mf(input logic [3:0] m, input logic z);
        @(posedge pclk);
        {cas_start, cas_mfa, ts16_zero} <= {1'b1, m, z};
        @(posedge pclk);
        {cas_start, cas_mfa, ts16_zero} <= {1'b0, ~m, ~z};
    endtask : cas_mf

    task automatic found();
        @(posedge pclk);
        cas_found <= 1'b1;
        @(posedge pclk);
        cas_found <= 1'b0;
    endtask : found

    task automatic crc_mf(input logic [5:0] m);
        @(posedge pclk);
        {crc_start, crc_mfa} <= {1'b1, m};
        @(posedge pclk);
        {crc_start, crc_mfa} <= {1'b0, ~m};
    endtask : crc_mf

    // Holds the sub-multi-frame strobe for n cycles in a row.
    task automatic sub_mf(input logic [3:0] c, input logic [3:0] r, input int n);
        @(posedge pclk);
        {sub_start, crc4_calc, crc4_rx} <= {1'b1, c, r};
        repeat (n) @(posedge pclk);
        {sub_start, crc4_calc, crc4_rx} <= {1'b0, ~c, ~r};
    endtask : sub_mf

    task automatic fbit();
        @(posedge pclk);
        fbit_err <= 1'b1;
        @(posedge pclk);
        fbit_err <= 1'b0;
    endtask : fbit

    task automatic align(input logic [7:0] p);
        @(posedge pclk);
        {al_found, al_pos} <= {1'b1, p};
        @(posedge pclk);
        {al_found, al_pos} <= {1'b0, ~p};
    endtask : align
endmodule : efs_line_model

// file: verif/tb.sv
// Self-checking bench for the E1 frame sync status and flag block.
`timescale 1ns/1ps

module tb;
    import efs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic crc_search_en, cas_mf_lost_state, irq, ce;
    logic bl, ol, cl, iw, cf, cs, tz, ms, ss, fe, af;
    logic [3:0] cm, c4c, c4r;
    logic [5:0] mm;
    logic [7:0] ap;
    int fails, num_checks;

    efs_line_model efs_line_model_inst (.pclk(pclk), .basic_lost(bl), .offl_lost(ol),
        .crc_lost(cl), .iw_mode(iw), .cas_found(cf), .cas_start(cs), .cas_mfa(cm),
        .ts16_zero(tz), .crc_start(ms), .crc_mfa(mm), .sub_start(ss), .crc4_calc(c4c),
        .crc4_rx(c4r), .fbit_err(fe), .al_found(af), .al_pos(ap));

    efs_frame_sync_status #(.WIN_CYC(2000)) efs_frame_sync_status_inst (.pclk(pclk),
        .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .basic_frame_lost_in(bl), .offline_frame_lost_in(ol),
        .crc_mf_lost_in(cl), .interwork_in(iw), .cas_mf_found(cf), .cas_mf_start(cs),
        .cas_mfa_bits(cm), .ts16_zero_mf(tz), .crc_mf_start(ms), .crc_mfa_bits(mm),
        .crc_submf_start(ss), .crc4_calc(c4c), .crc4_rx(c4r), .frame_bit_err(fe),
        .align_found(af), .align_pos(ap), .crc_search_en(crc_search_en),
        .cas_mf_lost_state(cas_mf_lost_state), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask : w

    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr_en, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic rd(input logic [9:0] i, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, {i, 2'b00}, 32'h0, r, e);
        check(r, x);
    endtask : rd

    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, {i, 2'b00}, d, r, e);
    endtask : wr

    task automatic t_reset();
        rd(IDX_STAT, 32'h0d);
        rd(IDX_EN0, 32'h0);
        rd(IDX_EN1, 32'h0);
        rd(IDX_CHG, 32'h0);
        rd(IDX_EVT, 32'h0);
        rd(IDX_MODE, 32'h0);
        check({30'h0, crc_search_en, cas_mf_lost_state}, 32'h3);
    endtask : t_reset

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        wr(IDX_EN0, 32'hffffffff);
        rd(IDX_EN0, 32'h1f);
        wr(IDX_EN1, 32'hff);
        rd(IDX_EN1, 32'hff);
        apb(1'b0, {10'h060, 2'b00}, 32'h0, r, e);
        check({e, r[30:0]}, 32'h80000000);
        apb(1'b1, 12'h141, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        rd(IDX_EN0, 32'h1f);
        wr(IDX_STAT, 32'h0);
        rd(IDX_STAT, 32'h0d);
        wr(IDX_EN0, 32'h0);
        wr(IDX_EN1, 32'h0);
    endtask : t_regs

    task automatic t_status();
        efs_line_model_inst.levels(4'ha);
        w(3);
        rd(IDX_STAT, 32'h1a);
        rd(IDX_CHG, 32'h17);
        check({31'h0, crc_search_en}, 32'h0);
        wr(IDX_MODE, 32'h1);
        w(3);
        check({31'h0, crc_search_en}, 32'h1);
        wr(IDX_MODE, 32'h0);
        wr(IDX_CHG, 32'h0);
        rd(IDX_CHG, 32'h17);
        wr(IDX_CHG, 32'h05);
        rd(IDX_CHG, 32'h12);
        wr(IDX_CHG, 32'h12);
        rd(IDX_CHG, 32'h0);
        efs_line_model_inst.levels(4'h5);
        w(3);
        rd(IDX_STAT, 32'h0d);
        rd(IDX_CHG, 32'h17);
    endtask : t_status

    task automatic t_irq();
        check({31'h0, irq}, 32'h0);
        wr(IDX_EN0, 32'h08);
        w(2);
        check({31'h0, irq}, 32'h0);
        wr(IDX_EN0, 32'h01);
        w(2);
        check({31'h0, irq}, 32'h1);
        wr(IDX_CHG, 32'h01);
        w(2);
        check({31'h0, irq}, 32'h0);
        wr(IDX_EN0, 32'h0);
        wr(IDX_CHG, 32'hff);
    endtask : t_irq

    task automatic t_cas();
        logic [2:0] md [4] = '{3'h0, 3'h4, 3'h2, 3'h6};
        logic [1:0] ex [4] = '{2'b00, 2'b00, 2'b11, 2'b01};
        efs_line_model_inst.levels(4'h0);
        efs_line_model_inst.found();
        w(2);
        check({31'h0, cas_mf_lost_state}, 32'h0);
        wr(IDX_CHG, 32'hff);
        wr(IDX_EVT, 32'hff);
        efs_line_model_inst.cas_mf(4'h1, 1'b0);
        rd(IDX_EVT, 32'ha0);
        efs_line_model_inst.cas_mf(4'h0, 1'b0);
        efs_line_model_inst.cas_mf(4'h2, 1'b0);
        w(2);
        check({31'h0, cas_mf_lost_state}, 32'h0);
        efs_line_model_inst.cas_mf(4'h4, 1'b0);
        w(2);
        check({31'h0, cas_mf_lost_state}, 32'h1);
        rd(IDX_CHG, 32'h08);
        wr(IDX_EVT, 32'hff);
        efs_line_model_inst.cas_mf(4'h0, 1'b0);
        rd(IDX_EVT, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(IDX_MODE, {29'h0, md[k]});
            efs_line_model_inst.found();
            w(2);
            efs_line_model_inst.cas_mf(4'h0, 1'b1);
            w(2);
            check({31'h0, cas_mf_lost_state}, {31'h0, ex[k][1]});
            efs_line_model_inst.cas_mf(4'h0, 1'b1);
            w(2);
            check({31'h0, cas_mf_lost_state}, {31'h0, ex[k][0]});
        end
        wr(IDX_MODE, 32'h0);
    endtask : t_cas

    task automatic t_crc();
        wr(IDX_EVT, 32'hff);
        efs_line_model_inst.sub_mf(4'h3, 4'h3, 1);
        rd(IDX_EVT, 32'h40);
        wr(IDX_EVT, 32'hff);
        efs_line_model_inst.sub_mf(4'h3, 4'h5, 1);
        rd(IDX_EVT, 32'h44);
        wr(IDX_EVT, 32'hff);
        efs_line_model_inst.crc_mf(6'h0b);
        rd(IDX_EVT, 32'h10);
        efs_line_model_inst.crc_mf(6'h0a);
        rd(IDX_EVT, 32'h18);
        wr(IDX_EVT, 32'hff);
        efs_line_model_inst.fbit();
        rd(IDX_EVT, 32'h02);
        wr(IDX_EVT, 32'hff);
        efs_line_model_inst.align(8'h05);
        efs_line_model_inst.align(8'h05);
        rd(IDX_EVT, 32'h0);
        efs_line_model_inst.align(8'h09);
        rd(IDX_EVT, 32'h01);
        wr(IDX_EN1, 32'h01);
        w(2);
        check({31'h0, irq}, 32'h1);
        wr(IDX_EN1, 32'hfe);
        w(2);
        check({31'h0, irq}, 32'h0);
        wr(IDX_EN1, 32'h0);
        efs_line_model_inst.levels(4'h4);
        w(3);
        wr(IDX_EVT, 32'hff);
        efs_line_model_inst.sub_mf(4'h1, 4'h2, 1);
        efs_line_model_inst.crc_mf(6'h00);
        rd(IDX_EVT, 32'h0);
    endtask : t_crc

    task automatic t_excess();
        wr(IDX_CHG, 32'hff);
        efs_line_model_inst.sub_mf(4'h1, 4'h2, 915);
        w(2);
        rd(IDX_CHG, 32'h0);
        efs_line_model_inst.levels(4'h0);
        w(3);
        efs_line_model_inst.sub_mf(4'h1, 4'h2, 914);
        w(2);
        rd(IDX_CHG, 32'h04);
        efs_line_model_inst.sub_mf(4'h1, 4'h2, 1);
        w(2);
        rd(IDX_CHG, 32'h24);
    endtask : t_excess

    // A frame bit error seen while the enable is low must leave no trace.
    task automatic t_hold();
        wr(IDX_EVT, 32'hff);
        @(posedge pclk);
        ce <= 1'b0;
        efs_line_model_inst.fbit();
        @(posedge pclk);
        ce <= 1'b1;
        rd(IDX_EVT, 32'h0);
        efs_line_model_inst.fbit();
        rd(IDX_EVT, 32'h02);
    endtask : t_hold

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        ce = 1'b1;
        fails = 0;
        num_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_status();
        t_irq();
        t_cas();
        t_crc();
        t_excess();
        t_hold();
        test_done();
    end
endmodule : tb
